// >>> hw/lpb_pkg.sv
// package of constants and the lane-code function for the local processor bus port
// Behaviour
// R1: everything sampled on rising local clock edge
// R2: strobe and select together start address phase
// R3: read data driven from next edge
// R4: tied latch strobe captures address at phase
// R5: latch-strobe trailing edge captures, phase starts work
// R6: master keeps address stable before both events
// R7: data phase needs all three readies active
// R8: device ready inserts waits, marks read data
// R9: write phase samples lane enables and data
// R10: style 0: burst_last inactive means more phases
// R11: style 1: burst_last active every data phase
// R12: read drive released at final data phase; in style 1 it is released a cycle later, once burst_last drops
// R13: configurable polarities and combined read/write mode
// R14: 8-bit width routes encoded byte to lane
// R15: 8-bit: A1,A0 on lanes 3,2; 1 high
// R16: 16-bit width; style picks encoded or direct
// R17: 16-bit direct: lane 3 picks half-word
// R18: 16-bit direct: lanes 1,0 are byte enables
// R19: 16-bit direct: master toggles lane 3 each phase
// R20: 16-bit direct: advance word after lane 3 high
// R21: 16-bit direct: lane enable 2 tied high
// R22: 16-bit encoded: processor upper half on low lines
// R23: encoded lane code translates to internal enables
// R24: 8-bit write touches only the selected byte
package lpb_pkg;
  localparam int unsigned ADDR_W    = 13;
  localparam int unsigned DATA_W    = 32;
  localparam logic [1:0]  BW_8      = 2'h0;
  localparam logic [1:0]  BW_16     = 2'h1;
  localparam logic        BES_DIRECT  = 1'h0;
  localparam logic        BES_ENCODED = 1'h1;
  localparam logic        BL_LASTMARK = 1'h0;
  localparam logic        BL_EVERY    = 1'h1;
  localparam logic        RW_SPLIT    = 1'h0;
  localparam logic        RW_COMBINED = 1'h1;
  localparam logic [3:0]  LANES_NONE  = 4'h0;
  localparam logic [3:0]  LANES_ALL   = 4'hf;
  localparam logic [31:0] MEM_RST     = 32'h0;

  // encoded lane code to active-low internal write enables, index = code
  function automatic logic [3:0] enc_to_int(input logic [3:0] code);
    logic [3:0] r;
    r = 4'hf;
    unique case (code[1:0])
      2'h0: r = (code[3:2] == 2'h1) ? 4'h7 : 4'h3;
      2'h1: r = 4'hb;
      2'h2: r = (code[3:2] == 2'h1) ? 4'hd : 4'hc;
      2'h3: r = 4'he;
    endcase
    return r;
  endfunction
endpackage

// >>> hw/lpb_if.sv
// interface joining the local processor and the shared-memory port
`timescale 1ns/1ps
`default_nettype none
interface lpb_if;
  logic        clk;
  logic        rst;
  logic        ale;
  logic        strobe;
  logic        select;
  logic        read;
  logic        write;
  logic [12:0] adr;
  logic        rdy_in_a;
  logic        rdy_in_b;
  logic        rdy_out;
  logic        burst_last;
  logic [3:0]  byte_lane_enables;
  logic [31:0] dq_m_o;
  logic        dq_m_oe;
  logic [31:0] dq_d_o;
  logic        dq_d_oe;
  logic [31:0] dq;

  // resolved level of the shared data lines
  assign dq = dq_d_oe ? dq_d_o : (dq_m_oe ? dq_m_o : 32'h0);

  modport dev (input clk, rst, ale, strobe, select, read, write, adr,
               rdy_in_a, rdy_in_b, burst_last, byte_lane_enables, dq,
               output rdy_out, dq_d_o, dq_d_oe);
  modport mst (input clk, rst, rdy_out, dq,
               output ale, strobe, select, read, write, adr, rdy_in_a,
               rdy_in_b, burst_last, byte_lane_enables, dq_m_o, dq_m_oe);
endinterface
`default_nettype wire

// >>> hw/lpb_lane_map.sv
// lane selection: turns width, style and lane inputs into byte write enables
`timescale 1ns/1ps
`default_nettype none
module lpb_lane_map (
  input  wire logic [1:0]  bus_width_select,
  input  wire logic        byte_enable_style,
  input  wire logic [3:0]  lanes,
  output logic [3:0]       wr_en,
  output logic [1:0]       byte_sel,
  output logic             half_hi
);
  always_comb begin
    wr_en    = 4'h0;
    byte_sel = lanes[3:2];
    half_hi  = lanes[3];
    if (bus_width_select == lpb_pkg::BW_8) begin
      wr_en = 4'h1 << lanes[3:2]; // R14 R24
    end else if (byte_enable_style == lpb_pkg::BES_DIRECT) begin // R16
      // active-low upper and lower byte enables
      wr_en = lanes[3] ? {~lanes[1], ~lanes[0], 2'h0}
                       : {2'h0, ~lanes[1], ~lanes[0]}; // R17 R18
    end else begin
      // internal enables are active low, bit n selects internal byte n
      wr_en = ~lpb_pkg::enc_to_int(lanes); // R22 R23
      half_hi = |wr_en[3:2];
    end
  end
endmodule
`default_nettype wire

// >>> hw/lpb_dev.sv
// device end: shared memory reached through the local processor bus
`timescale 1ns/1ps
`default_nettype none
module lpb_dev #(
  parameter int unsigned DEPTH = 8192
) (
  lpb_if.dev               bus,
  input  wire logic [1:0]  bus_width_select,
  input  wire logic        byte_enable_style,
  input  wire logic        burst_style,
  input  wire logic        rw_mode,
  input  wire logic        ale_act_hi,
  input  wire logic        strobe_act_hi,
  input  wire logic        burst_last_act_hi,
  input  wire logic        rdy_out_act_hi,
  input  wire logic        ale_tied,
  input  wire logic        mem_ready,
  output logic             busy
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01
  } lpb_st_e;

  lpb_st_e     st_r;
  logic [12:0] addr_r;
  logic [12:0] ale_addr_r;
  logic        ale_q_r;
  logic        rd_r;
  logic        hi_r;
  logic [31:0] rdata_r;
  logic        dq_oe_r;
  logic        rd_fresh_r;
  logic [31:0] mem [DEPTH];

  logic ale_act, strobe_act, last_act, is_rd, addr_ph, data_ph, final_ph;
  logic rdy_act;
  logic [3:0] wr_en;
  logic [1:0] byte_sel;
  logic       half_hi;

  // ----------------------------------------------------------------
  // decode of configurable polarities
  // ----------------------------------------------------------------
  assign ale_act    = bus.ale ~^ ale_act_hi; // R13
  assign strobe_act = bus.strobe ~^ strobe_act_hi; // R13
  assign last_act   = bus.burst_last ~^ burst_last_act_hi; // R13
  // combined mode: read pin high means read, low means write
  assign is_rd = (rw_mode == lpb_pkg::RW_COMBINED) ? bus.read
                                                   : bus.read & ~bus.write;
  assign addr_ph = (st_r == ST_IDLE) && strobe_act && bus.select; // R2
  // read data is registered: hold ready off until it matches the address;
  // the every-phase trailing cycle keeps ready so release meets a phase
  assign rdy_act = mem_ready && (!rd_r || rd_fresh_r ||
                   (burst_style == lpb_pkg::BL_EVERY && !last_act)); // R8
  assign bus.rdy_out = (rdy_act && st_r == ST_DATA) ~^ rdy_out_act_hi; // R8
  assign data_ph = (st_r == ST_DATA) && rdy_act && bus.rdy_in_a
                   && bus.rdy_in_b
                   && (burst_style == lpb_pkg::BL_LASTMARK || last_act); // R7
  // lastmark style: active marks final; every style: the end is only
  // seen once burst_last has dropped after the last phase
  assign final_ph = (burst_style == lpb_pkg::BL_LASTMARK)
                    ? (data_ph && last_act)
                    : (st_r == ST_DATA && !last_act); // R10 R11
  assign busy = (st_r == ST_DATA);

  lpb_lane_map u_map (
    .bus_width_select  (bus_width_select),
    .byte_enable_style (byte_enable_style),
    .lanes             (bus.byte_lane_enables),
    .wr_en             (wr_en),
    .byte_sel          (byte_sel),
    .half_hi           (half_hi)
  );

  // ----------------------------------------------------------------
  // address capture
  // ----------------------------------------------------------------
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      ale_q_r    <= 1'b0;
      ale_addr_r <= 13'h0;
    end else begin
      ale_q_r <= ale_act;
      if (ale_q_r && !ale_act) begin
        ale_addr_r <= bus.adr; // R5
      end
    end
  end

  always_ff @(posedge bus.clk or posedge bus.rst) begin // R1
    if (bus.rst) begin
      st_r <= ST_IDLE;
      rd_r <= 1'b0;
      addr_r <= 13'h0;
      hi_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (addr_ph) begin
            st_r <= ST_DATA;
            rd_r <= is_rd; // R2
            addr_r <= ale_tied ? bus.adr : ale_addr_r; // R4 R5
            hi_r <= bus.byte_lane_enables[3];
          end
        end
        ST_DATA: begin
          if (final_ph) begin
            st_r <= ST_IDLE;
          end else if (data_ph) begin
            // advance the word every non-final phase, except in 16-bit direct mode only after the upper half
            if (bus_width_select != lpb_pkg::BW_16 ||
                byte_enable_style != lpb_pkg::BES_DIRECT || hi_r) begin
              addr_r <= addr_r + 13'h1; // R10 R20
            end
            hi_r <= ~hi_r;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory and write path
  // ----------------------------------------------------------------
  always_ff @(posedge bus.clk) begin
    if (data_ph && !rd_r) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_en[b]) begin
          if (bus_width_select == lpb_pkg::BW_8) begin
            mem[addr_r][b*8 +: 8] <= bus.dq[7:0]; // R9 R24
          end else begin
            mem[addr_r][b*8 +: 8] <= bus.dq[(b%2)*8 +: 8]; // R9
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      rd_fresh_r <= 1'b0;
    end else begin
      rd_fresh_r <= (st_r == ST_DATA) && !data_ph; // R8
    end
  end

  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      dq_oe_r <= 1'b0;
    end else if (addr_ph && is_rd) begin
      dq_oe_r <= 1'b1; // R3
    end else if (final_ph) begin
      dq_oe_r <= 1'b0; // R12
    end
  end

  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      rdata_r <= lpb_pkg::MEM_RST;
    end else if (st_r == ST_DATA && rd_r) begin
      if (bus_width_select == lpb_pkg::BW_8) begin
        rdata_r <= {24'h0, mem[addr_r][byte_sel*8 +: 8]}; // R14 R24
      end else if (half_hi) begin
        rdata_r <= {16'h0, mem[addr_r][31:16]}; // R17 R22
      end else begin
        rdata_r <= {16'h0, mem[addr_r][15:0]}; // R17
      end
    end
  end

  assign bus.dq_d_o  = rdata_r;
  assign bus.dq_d_oe = dq_oe_r; // R8 R12
endmodule
`default_nettype wire

// >>> hw/lpb_mst.sv
// master end: local processor issuing single and burst transfers
`timescale 1ns/1ps
`default_nettype none
module lpb_mst (
  lpb_if.mst               bus,
  input  wire logic        go,
  input  wire logic        go_read,
  input  wire logic [12:0] go_addr,
  input  wire logic [3:0]  go_lanes,
  input  wire logic [31:0] go_data,
  input  wire logic [3:0]  go_count,
  input  wire logic        burst_style,
  input  wire logic        toggle_lane3,
  output logic [31:0]      rdata,
  output logic             rvalid,
  output logic             done
);
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ADDR = 2'b01,
    MS_DATA = 2'b10
  } lpb_ms_e;

  lpb_ms_e    st_r;
  logic [3:0] left_r;
  logic       rd_r;
  logic       phase;

  assign phase = (st_r == MS_DATA) && bus.rdy_out; // R7

  always_ff @(posedge bus.clk or posedge bus.rst) begin // R1
    if (bus.rst) begin
      st_r <= MS_IDLE;
      left_r <= 4'h0;
      rd_r <= 1'b0;
      bus.adr <= 13'h0;
      bus.byte_lane_enables <= 4'hf;
      bus.dq_m_o <= 32'h0;
      rdata <= 32'h0;
      rvalid <= 1'b0;
      done <= 1'b0;
    end else begin
      rvalid <= 1'b0;
      done <= 1'b0;
      unique case (st_r)
        MS_IDLE: begin
          if (go) begin
            st_r <= MS_ADDR;
            rd_r <= go_read;
            left_r <= go_count;
            bus.adr <= go_addr; // R6
            bus.byte_lane_enables <= go_lanes; // R15 R21
            bus.dq_m_o <= go_data;
          end
        end
        MS_ADDR: st_r <= MS_DATA;
        MS_DATA: begin
          if (phase) begin
            rdata <= bus.dq;
            rvalid <= rd_r;
            if (toggle_lane3) begin
              bus.byte_lane_enables[3] <= ~bus.byte_lane_enables[3]; // R19
            end
            if (left_r == 4'h0) begin
              st_r <= MS_IDLE;
              done <= 1'b1;
            end else begin
              left_r <= left_r - 4'h1;
            end
          end
        end
        default: st_r <= MS_IDLE;
      endcase
    end
  end

  always_comb begin
    bus.ale = 1'b1;
    bus.strobe = (st_r == MS_ADDR);
    bus.select = (st_r == MS_ADDR);
    bus.read = rd_r;
    bus.write = ~rd_r;
    bus.rdy_in_a = 1'b1;
    bus.rdy_in_b = 1'b1;
    bus.dq_m_oe = (st_r == MS_DATA) && !rd_r;
    // burst_last active-high as seen by this end
    bus.burst_last = (burst_style == lpb_pkg::BL_LASTMARK)
                     ? (left_r == 4'h0) : (st_r == MS_DATA); // R10 R11
  end
endmodule
`default_nettype wire

// >>> dv/lpb_asserts.sv
// concurrent checks on the bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module lpb_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic select,
  input wire logic read,
  input wire logic rdy_in_a,
  input wire logic rdy_in_b,
  input wire logic rdy_out,
  input wire logic burst_last,
  input wire logic dq_d_oe,
  input wire logic burst_style
);
  logic xfer_r;
  logic rd_r;
  logic ph_q_r;
  wire  ph  = rdy_in_a && rdy_in_b && rdy_out;
  wire  adr = strobe && select && !xfer_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // every-phase style: the end is only visible one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_r <= 1'b0;
      rd_r   <= 1'b0;
      ph_q_r <= 1'b0;
    end else begin
      ph_q_r <= ph;
      if (adr) begin
        xfer_r <= 1'b1;
        rd_r   <= read;
      end else if (ph && burst_last && burst_style == lpb_pkg::BL_LASTMARK) begin
        xfer_r <= 1'b0;
      end else if (ph_q_r && !burst_last && burst_style == lpb_pkg::BL_EVERY) begin
        xfer_r <= 1'b0;
      end
    end
  end
  property p_rd_start;
    adr && read |=> dq_d_oe;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read not driven");
  property p_wr_quiet;
    adr && !read |=> !dq_d_oe [*2];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write drove");
  property p_oe_cause;
    $rose(dq_d_oe) |-> $past(adr && read);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
  property p_rd_release;
    dq_d_oe && ph && burst_last && burst_style == lpb_pkg::BL_LASTMARK
      |=> !dq_d_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("no release");
  property p_oe_hold;
    dq_d_oe && !ph |=> dq_d_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("early release");
  property p_oe_fall;
    $fell(dq_d_oe) |-> $past(ph);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("release off phase");
  property p_rdy_in_xfer;
    rdy_out |-> xfer_r;
  endproperty
  a_rdy_in_xfer: assert property (p_rdy_in_xfer) else $error("idle ready");
  property p_wr_no_drive;
    xfer_r && !rd_r |-> !dq_d_oe;
  endproperty
  a_wr_no_drive: assert property (p_wr_no_drive) else $error("drive in write");
endmodule
`default_nettype wire

// >>> dv/lpb_bench.sv
// self-checking bench driving both ends of the local processor bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("wrong value at %0t ns: got %h want %h", $time, g, e); \
    end \
  end
module lpb_bench;
  // ------------
  // signals
  // ------------
  lpb_if       bus ();
  logic        go, go_read, bstyle, tog, pol, ale_t, rwm, mem_ready, bes;
  logic [12:0] go_addr;
  logic [3:0]  go_lanes, go_count;
  logic [31:0] go_data, rdata;
  logic [1:0]  bws;
  logic [2:0]  sh;
  logic        rvalid, done, busy;
  logic [31:0] rq[$];
  logic [7:0]  bv[4] = '{8'h3c, 8'h5a, 8'ha5, 8'hc3};
  int          num_errors = 0;
  int          num_checks = 0;
  lpb_dev #(.DEPTH(8192)) lpb_dev_i (.bus(bus.dev),
    .bus_width_select(bws), .byte_enable_style(bes), .burst_style(bstyle),
    .rw_mode(rwm), .ale_act_hi(pol), .strobe_act_hi(pol),
    .burst_last_act_hi(pol), .rdy_out_act_hi(pol), .ale_tied(ale_t),
    .mem_ready(mem_ready), .busy(busy));
  lpb_mst lpb_mst_i (.bus(bus.mst), .go(go), .go_read(go_read),
    .go_addr(go_addr), .go_lanes(go_lanes), .go_data(go_data),
    .go_count(go_count), .burst_style(bstyle), .toggle_lane3(tog),
    .rdata(rdata), .rvalid(rvalid), .done(done));
  lpb_asserts lpb_asserts_i (.clk(bus.clk), .rst(bus.rst),
    .strobe(bus.strobe), .select(bus.select), .read(bus.read),
    .rdy_in_a(bus.rdy_in_a), .rdy_in_b(bus.rdy_in_b),
    .rdy_out(bus.rdy_out), .burst_last(bus.burst_last),
    .dq_d_oe(bus.dq_d_oe), .burst_style(bstyle));
  initial begin
    bus.clk = 1'b0;
    forever #50 bus.clk = ~bus.clk;
  end
  // memory side holds off three cycles so first read data is fresh
  always @(posedge bus.clk) begin
    sh <= {sh[1:0], go};
    mem_ready <= ~|{sh[1:0], go};
    if (rvalid === 1'b1) rq.push_back(rdata);
  end
  // ------------
  // tasks
  // ------------
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [3:0] ln, input logic [31:0] d,
                      input logic [3:0] n);
    int k;
    go_read  <= rd;
    go_addr  <= a;
    go_lanes <= ln;
    go_data  <= d;
    go_count <= n;
    go       <= 1'b1;
    @(posedge bus.clk);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(posedge bus.clk);
      k++;
    end
    `CHK(k < 60, 1'b1)
    @(posedge bus.clk);
  endtask
  task automatic rchk(input logic [12:0] a, input logic [3:0] ln,
                      input logic [15:0] e);
    rq.delete();
    xfer(1'b1, a, ln, 32'h0, 4'h0);
    `CHK(rq.size(), 1)
    `CHK(bws == lpb_pkg::BW_8 ? {8'h0, rq[0][7:0]} : rq[0][15:0], e)
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------
  // tests
  // ------------
  initial begin
    repeat (5000) @(posedge bus.clk);
    num_errors++;
    $display("wrong value at %0t ns: run hung", $time);
    conclude();
  end
  initial begin
    bus.rst = 1'b1;
    {go, go_read, go_addr, go_lanes, go_data, go_count, tog, sh} = '0;
    bstyle = lpb_pkg::BL_LASTMARK;
    {pol, ale_t, mem_ready} = 3'h7;
    rwm = lpb_pkg::RW_SPLIT;
    bws = lpb_pkg::BW_8;
    bes = lpb_pkg::BES_DIRECT;
    repeat (4) @(posedge bus.clk);
    bus.rst <= 1'b0;
    @(posedge bus.clk);
    for (int i = 0; i < 4; i++) xfer(1'b0, 13'h5, {2'(i), 2'h3}, bv[i], 4'h0);
    for (int i = 0; i < 4; i++) rchk(13'h5, {2'(i), 2'h3}, bv[i]);
    $display("test byte lanes done");
    bws <= lpb_pkg::BW_16;
    rchk(13'h5, 4'h4, {bv[1], bv[0]});
    rchk(13'h5, 4'hc, {bv[3], bv[2]});
    xfer(1'b0, 13'h5, 4'h6, 32'h7788, 4'h0);
    rchk(13'h5, 4'h4, {bv[1], 8'h88});
    xfer(1'b0, 13'h6, 4'h0, 32'h0, 4'h0);
    xfer(1'b0, 13'h7, 4'h0, 32'h0, 4'h0);
    $display("test half words done");
    for (int s = 0; s < 2; s++) begin
      bstyle <= s[0];
      tog <= 1'b1;
      rq.delete();
      xfer(1'b1, 13'h5, 4'hc, 32'h0, 4'h1);
      `CHK(rq.size(), 2)
      `CHK(rq[0][15:0], {bv[3], bv[2]})
      `CHK(rq[1][15:0], 16'h0)
    end
    $display("test bursts done");
    bstyle <= lpb_pkg::BL_LASTMARK;
    tog <= 1'b0;
    bes <= lpb_pkg::BES_ENCODED;
    xfer(1'b0, 13'h7, 4'h8, 32'hbeef, 4'h0);
    bes <= lpb_pkg::BES_DIRECT;
    rchk(13'h7, 4'hc, 16'hbeef);
    rchk(13'h7, 4'h4, 16'h0);
    $display("test encoded lanes done");
    conclude();
  end
endmodule
`default_nettype wire
